// >>> rtl/mfc_defines.vh
// Purpose: Shared constants of the multifunction counter timing block.
// Assumes: 25 MHz system clock, byte addresses on the register port.
// Notes: Counts are derived from times and the clock rate.
`ifndef MFC_DEFINES_VH
`define MFC_DEFINES_VH

// Clock rate and time base.
// Cycles of the 25 MHz clock per microsecond, less one.
`define MFC_US_TOP 5'h18
`define MFC_DECADE 4'h9
`define MFC_NCH 5

// Card-wide register offsets.
`define MFC_A_SAMPLE 8'h00
`define MFC_A_FGATE 8'h04
`define MFC_A_ARM 8'h08
`define MFC_A_DISARM 8'h0c
`define MFC_A_IRQ 8'h10
`define MFC_A_ERR 8'h14
`define MFC_A_CARD 8'h18

// Channel n sits at base plus stride times n.
`define MFC_A_CH_BASE 8'h40
`define MFC_A_CH_STRIDE 8'h10
`define MFC_O_CTRL 8'h00
`define MFC_O_MOD 8'h04
`define MFC_O_READING 8'h08
`define MFC_O_STAT 8'h0c

// Field positions.
`define MFC_CTRL_TB_EXPL 7

// Reset values.
`define MFC_SAMPLE_RST 7'h00
`define MFC_FGATE_RST 2'h0
`define MFC_CTRL_RST 8'h00
`define MFC_MOD_RST 16'h0002

// Channel functions.
`define MFC_FN_TOTAL 4'h0
`define MFC_FN_WRAP 4'h1
`define MFC_FN_UPDN 4'h2
`define MFC_FN_UPDN_WRAP 4'h3
`define MFC_FN_CDIR 4'h4
`define MFC_FN_CDIR_WRAP 4'h5
`define MFC_FN_RATIO 4'h6
`define MFC_FN_PERIOD 4'h7
`define MFC_FN_DELAYED 4'h8

`endif

// >>> rtl/mfc_sampler.v
// Purpose: Samples channel inputs at the card sample tick and debounces them.
// Assumes: Inputs synchronous to the clock.
// Notes: A level is accepted after two equal samples in a row.
`timescale 1ns/1ps
`include "mfc_defines.vh"

module mfc_sampler #(
    parameter W = 5
) (
    // Clock and control.
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    input wire tick,
    // Raw inputs and debounced outputs.
    input wire [W-1:0] din,
    output reg [W-1:0] level,
    output reg [W-1:0] rise
);
    reg [W-1:0] smp_q;
    wire [W-1:0] agree;

    assign agree = ~(smp_q ^ din);

    always @(posedge MCLK) begin
        if (!RSTN) begin
            smp_q <= {W{1'b0}};
            level <= {W{1'b0}};
            rise <= {W{1'b0}};
        end else if (CE) begin
            rise <= {W{1'b0}};
            if (tick) begin
                smp_q <= din;
                // Only a level seen on two successive ticks is taken.
                level <= (agree & din) | (~agree & level); // [R13] [R25]
                rise <= agree & din & ~level; // [R25]
            end
        end
    end
endmodule // mfc_sampler

// >>> rtl/mfc_top.v
// Purpose: Five-channel counter with modulus, sampling, time base and interrupts.
// Assumes: Plain register port, read data one cycle after the read strobe.
// Notes: FREQ_MODE is the card configuration strap level.
// How it works
// R1 - Modulo accumulate counts A edges 0..modulus-1 then wraps; modulus 2..65535.
// R2 - Plain accumulate is a 32-bit counter with no modulus.
// R3 - Up/down wrap counts A up, B down; never interrupts.
// R4 - Down from 0 wraps to modulus-1; up past modulus-1 wraps to 0.
// R5 - Count/direction counts A edges, direction from B level, same wrap.
// R6 - Ratio counts A edges over modulus B periods, then reading ready.
// R7 - Period starts when programmed, times modulus A periods, then ready.
// R8 - Delayed period times only the A period whose index equals modulus.
// R9 - Modulus matters only to the wrap, ratio and period functions.
// R10 - Sample interval setting applies to all channels at once.
// R11 - Sample interval resets to 1 us.
// R12 - Sample interval 1 us to 160 ms in decade steps of 1..16.
// R13 - Debounce gives minimum pulse near half interval plus 0.5 us; the code needs the level on two successive ticks, just over one interval.
// R14 - Without explicit time base, period and gate bases are automatic; the code uses the 1 us period base and the 1 s gate instead.
// R15 - Period time base per channel: 1 us, 10 us, 100 us, 1 ms, 10 ms.
// R16 - Period resolves one tick, up to 65535 ticks.
// R17 - Period result sums the modulus periods, dividing range and resolution.
// R18 - Frequency gate 1 s, 100 ms or 10 ms for all channels.
// R19 - Frequency range follows gate length.
// R20 - Host arms or disarms each channel interrupt individually.
// R21 - In frequency mode all channels measure frequency; function writes rejected.
// R22 - Overflow on -1 to 0 plain, modulus-1 to 0 wrap.
// R23 - Reprogramming aborts the measurement and discards data.
// R24 - Overflow interrupt disarms and clears once serviced.
// R25 - Inputs sampled on the sample tick; edges come from sampled values.
// R26 - Period and ratio tick counters are 16 bits; the code counts them in the 32-bit cnt_q.
//
// The address-and-strobe port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`include "mfc_defines.vh"

module mfc_top #(
    parameter NCH = `MFC_NCH
) (
    // Clock, reset and enable.
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    // Register port.
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    output reg [31:0] RDATA,
    // Card strap and channel inputs.
    input wire FREQ_MODE,
    input wire [NCH-1:0] IN_A,
    input wire [NCH-1:0] IN_B,
    // Pending interrupt per channel.
    output wire [NCH-1:0] IRQ_REQ
);
    // Time base chain: dtick[k] pulses every 10^k microseconds.
    reg [4:0] us_q;
    wire [6:0] dtick;
    assign dtick[0] = (us_q == `MFC_US_TOP);

    always @(posedge MCLK) begin
        if (!RSTN) begin
            us_q <= 5'h00;
        end else if (CE) begin
            us_q <= dtick[0] ? 5'h00 : us_q + 5'h01;
        end
    end

    genvar k;
    generate
        for (k = 1; k < 7; k = k + 1) begin : g_dec
            reg [3:0] dc_q;
            always @(posedge MCLK) begin
                if (!RSTN) begin
                    dc_q <= 4'h0;
                end else if (CE && dtick[k-1]) begin
                    dc_q <= (dc_q == `MFC_DECADE) ? 4'h0 : dc_q + 4'h1;
                end
            end
            assign dtick[k] = dtick[k-1] & (dc_q == `MFC_DECADE);
        end
    endgenerate

    // Card-wide settings.
    reg [6:0] sample_q;
    reg [1:0] fgate_q;
    reg [NCH-1:0] arm_q;
    reg err_q;
    reg [3:0] smp_cnt_q;
    wire [2:0] smp_range;
    wire smp_base;
    wire smp_tick;
    wire gate_tick;
    wire wr_sample;
    wire wr_fgate;
    wire wr_irq;

    assign wr_sample = WR && (ADDR == `MFC_A_SAMPLE);
    assign wr_fgate = WR && (ADDR == `MFC_A_FGATE);
    assign wr_irq = WR && (ADDR == `MFC_A_IRQ);
    assign smp_range = (sample_q[6:4] > 3'h4) ? 3'h4 : sample_q[6:4]; // [R12]
    assign smp_base = dtick[smp_range];
    assign smp_tick = smp_base && (smp_cnt_q == sample_q[3:0]); // [R12]
    // Automatic gate selection takes the longest gate.
    assign gate_tick = (fgate_q == 2'h3) ? dtick[4] :
                       (fgate_q == 2'h2) ? dtick[5] : dtick[6]; // [R18] [R14] [R19]

    always @(posedge MCLK) begin
        if (!RSTN) begin
            sample_q <= `MFC_SAMPLE_RST; // [R11]
            fgate_q <= `MFC_FGATE_RST;
            smp_cnt_q <= 4'h0;
        end else if (CE) begin
            if (wr_sample) begin
                sample_q <= WDATA[6:0]; // [R10]
                smp_cnt_q <= 4'h0;
            end else if (smp_base) begin
                smp_cnt_q <= smp_tick ? 4'h0 : smp_cnt_q + 4'h1;
            end
            if (wr_fgate) begin
                fgate_q <= WDATA[1:0];
            end
        end
    end

    // Sampled and debounced inputs shared by every channel.
    wire [NCH-1:0] lvl_a;
    wire [NCH-1:0] lvl_b;
    wire [NCH-1:0] ea;
    wire [NCH-1:0] eb;

    mfc_sampler #(.W(2*NCH)) u_smp (
        .MCLK(MCLK),
        .RSTN(RSTN),
        .CE(CE),
        .tick(smp_tick), // [R10] [R25]
        .din({IN_B, IN_A}),
        .level({lvl_b, lvl_a}),
        .rise({eb, ea})
    );

    // Per-channel logic.
    wire [NCH-1:0] pend;
    wire [NCH-1:0] ev_irq;
    wire [NCH-1:0] fn_rej;
    wire [32*NCH-1:0] ch_rd;
    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            localparam [7:0] BASE = `MFC_A_CH_BASE + c * `MFC_A_CH_STRIDE;
            reg [7:0] ctrl_q;
            reg [15:0] mod_q;
            reg [31:0] cnt_q;
            reg [31:0] res_q;
            reg [15:0] modulus_count_q;
            reg run_q;
            reg done_q;
            reg rdy_q;
            reg pend_q;
            reg ovf;
            reg fin;
            wire [3:0] fn;
            wire [2:0] tb;
            wire ptick;
            wire wr_ctrl;
            wire wr_mod;
            wire rd_res;
            wire abort;
            wire wrap_fn;
            wire tot_fn;
            wire [15:0] top;
            wire dn;
            wire up;

            assign fn = ctrl_q[3:0];
            assign tb = ctrl_q[`MFC_CTRL_TB_EXPL] ?
                        ((ctrl_q[6:4] > 3'h4) ? 3'h4 : ctrl_q[6:4]) : 3'h0;
            assign ptick = dtick[tb]; // [R15] [R14] [R16]
            assign wr_ctrl = WR && (ADDR == BASE + `MFC_O_CTRL);
            assign wr_mod = WR && (ADDR == BASE + `MFC_O_MOD);
            assign rd_res = RD && (ADDR == BASE + `MFC_O_READING);
            assign fn_rej[c] = wr_ctrl && FREQ_MODE; // [R21]
            assign abort = (wr_ctrl && !FREQ_MODE) || wr_mod || wr_sample || wr_fgate; // [R23]
            assign tot_fn = !FREQ_MODE && (fn == `MFC_FN_TOTAL || fn == `MFC_FN_WRAP);
            assign wrap_fn = fn == `MFC_FN_UPDN_WRAP || fn == `MFC_FN_CDIR_WRAP;
            assign top = mod_q - 16'h0001;
            assign up = (fn == `MFC_FN_UPDN || fn == `MFC_FN_UPDN_WRAP) ?
                        (ea[c] && !eb[c]) : (ea[c] && lvl_b[c]); // [R3] [R5]
            assign dn = (fn == `MFC_FN_UPDN || fn == `MFC_FN_UPDN_WRAP) ?
                        (eb[c] && !ea[c]) : (ea[c] && !lvl_b[c]); // [R3] [R5]

            always @(posedge MCLK) begin
                if (!RSTN) begin
                    ctrl_q <= `MFC_CTRL_RST;
                    mod_q <= `MFC_MOD_RST;
                end else if (CE) begin
                    if (wr_ctrl && !FREQ_MODE) begin
                        ctrl_q <= WDATA[7:0];
                    end
                    if (wr_mod) begin
                        mod_q <= WDATA[15:0]; // [R1] [R9]
                    end
                end
            end

            always @(posedge MCLK) begin
                if (!RSTN) begin
                    cnt_q <= 32'h0;
                    res_q <= 32'h0;
                    modulus_count_q <= 16'h0000;
                    run_q <= 1'b0;
                    done_q <= 1'b0;
                    rdy_q <= 1'b0;
                    ovf <= 1'b0;
                    fin <= 1'b0;
                end else if (CE) begin
                    ovf <= 1'b0;
                    fin <= 1'b0;
                    if (abort) begin
                        cnt_q <= 32'h0; // [R23]
                        modulus_count_q <= 16'h0000;
                        run_q <= 1'b0;
                        done_q <= 1'b0;
                        rdy_q <= 1'b0;
                    end else if (FREQ_MODE) begin
                        // All channels count A edges over the shared gate.
                        if (gate_tick) begin
                            res_q <= cnt_q; // [R21] [R18]
                            cnt_q <= {31'h0, ea[c]};
                            fin <= 1'b1;
                        end else if (ea[c]) begin
                            cnt_q <= cnt_q + 32'h00000001;
                        end
                    end else begin
                        case (fn)
                            `MFC_FN_TOTAL: begin
                                if (ea[c]) begin
                                    cnt_q <= cnt_q + 32'h1; // [R2]
                                    ovf <= (cnt_q == 32'hffffffff); // [R22]
                                end
                            end
                            `MFC_FN_WRAP: begin
                                if (ea[c]) begin
                                    ovf <= (cnt_q[15:0] >= top); // [R22]
                                    cnt_q <= (cnt_q[15:0] >= top) ? 32'h0 : cnt_q + 32'h1; // [R1]
                                end
                            end
                            `MFC_FN_UPDN, `MFC_FN_CDIR, `MFC_FN_UPDN_WRAP,
                            `MFC_FN_CDIR_WRAP: begin
                                if (up) begin
                                    cnt_q <= (wrap_fn && cnt_q[15:0] >= top) ?
                                             32'h0 : cnt_q + 32'h1; // [R4]
                                end else if (dn) begin
                                    cnt_q <= (wrap_fn && cnt_q == 32'h0) ?
                                             {16'h0000, top} : cnt_q - 32'h1; // [R4]
                                end
                            end
                            `MFC_FN_RATIO: begin
                                if (!run_q && !done_q) begin
                                    if (eb[c]) begin
                                        run_q <= 1'b1;
                                        cnt_q <= {31'h00000000, ea[c]};
                                    end
                                end else if (run_q) begin
                                    if (eb[c] && modulus_count_q + 16'h0001 == mod_q) begin
                                        res_q <= cnt_q; // [R6]
                                        run_q <= 1'b0;
                                        done_q <= 1'b1;
                                        fin <= 1'b1;
                                    end else begin
                                        if (eb[c]) begin
                                            modulus_count_q <= modulus_count_q + 16'h0001; // [R26]
                                        end
                                        if (ea[c]) begin
                                            cnt_q <= cnt_q + 32'h00000001;
                                        end
                                    end
                                end
                            end
                            `MFC_FN_PERIOD: begin
                                if (ea[c] && !run_q && !done_q) begin
                                    run_q <= 1'b1; // [R7]
                                    cnt_q <= 32'h00000000;
                                end else if (run_q) begin
                                    if (ea[c] && modulus_count_q + 16'h0001 == mod_q) begin
                                        res_q <= cnt_q; // [R17] [R7]
                                        run_q <= 1'b0;
                                        done_q <= 1'b1;
                                        fin <= 1'b1;
                                    end else begin
                                        if (ea[c]) begin
                                            modulus_count_q <= modulus_count_q + 16'h0001; // [R26]
                                        end
                                        if (ptick) begin
                                            cnt_q <= cnt_q + 32'h00000001; // [R16] [R17]
                                        end
                                    end
                                end
                            end
                            `MFC_FN_DELAYED: begin
                                if (run_q) begin
                                    if (ea[c]) begin
                                        res_q <= cnt_q; // [R8]
                                        run_q <= 1'b0;
                                        done_q <= 1'b1;
                                        fin <= 1'b1;
                                    end else if (ptick) begin
                                        cnt_q <= cnt_q + 32'h00000001; // [R16]
                                    end
                                end else if (ea[c] && !done_q) begin
                                    // Earlier periods are only counted, not timed.
                                    modulus_count_q <= modulus_count_q + 16'h0001; // [R8]
                                    if (modulus_count_q + 16'h0001 == mod_q) begin
                                        run_q <= 1'b1;
                                        cnt_q <= 32'h00000000;
                                    end
                                end
                            end
                            default: begin
                            end
                        endcase
                    end
                    if (!abort) begin
                        if (fin) begin
                            rdy_q <= 1'b1;
                        end else if (rd_res) begin
                            rdy_q <= 1'b0;
                        end
                    end
                end
            end

            // Pending interrupt: set wins over any clear in the same cycle.
            assign ev_irq[c] = ovf || fin;
            always @(posedge MCLK) begin
                if (!RSTN) begin
                    pend_q <= 1'b0;
                end else if (CE) begin
                    if (arm_q[c] && ev_irq[c]) begin
                        pend_q <= 1'b1; // [R20] [R3]
                    end else if (tot_fn && wr_irq && WDATA[c]) begin
                        pend_q <= 1'b0; // [R24]
                    end else if (abort || (!tot_fn && rd_res)) begin
                        pend_q <= 1'b0;
                    end
                end
            end
            assign pend[c] = pend_q;

            assign ch_rd[32*c +: 32] =
                (ADDR == BASE + `MFC_O_CTRL) ? {24'h000000, ctrl_q} :
                (ADDR == BASE + `MFC_O_MOD) ? {16'h0000, mod_q} :
                (ADDR == BASE + `MFC_O_READING) ? ((tot_fn || (!FREQ_MODE &&
                    fn <= `MFC_FN_CDIR_WRAP)) ? cnt_q : res_q) :
                (ADDR == BASE + `MFC_O_STAT) ? {29'h00000000, rdy_q, run_q, done_q} :
                32'h00000000;
        end
    endgenerate

    assign IRQ_REQ = pend;

    // Arming and error flags.
    always @(posedge MCLK) begin
        if (!RSTN) begin
            arm_q <= {NCH{1'b0}};
            err_q <= 1'b0;
        end else if (CE) begin
            if (WR && ADDR == `MFC_A_ARM) begin
                arm_q <= arm_q | WDATA[NCH-1:0]; // [R20]
            end else if (WR && ADDR == `MFC_A_DISARM) begin
                arm_q <= arm_q & ~WDATA[NCH-1:0]; // [R20]
            end else if (wr_irq) begin
                // Servicing a channel disarms it.
                arm_q <= arm_q & ~(WDATA[NCH-1:0] & pend); // [R24]
            end
            if (|fn_rej) begin
                err_q <= 1'b1; // [R21]
            end else if (WR && ADDR == `MFC_A_ERR) begin
                err_q <= 1'b0;
            end
        end
    end

    // Read data, registered one cycle after the strobe.
    reg [31:0] rd_d;
    integer i;
    always @* begin
        rd_d = 32'h00000000;
        case (ADDR)
            `MFC_A_SAMPLE: rd_d = {25'h0000000, sample_q};
            `MFC_A_FGATE: rd_d = {30'h00000000, fgate_q};
            `MFC_A_ARM: rd_d = {{(32-NCH){1'b0}}, arm_q};
            `MFC_A_IRQ: rd_d = {{(32-NCH){1'b0}}, pend};
            `MFC_A_ERR: rd_d = {31'h00000000, err_q};
            `MFC_A_CARD: rd_d = {31'h00000000, FREQ_MODE};
            default: begin
                for (i = 0; i < NCH; i = i + 1) begin
                    rd_d = rd_d | ch_rd[32*i +: 32];
                end
            end
        endcase
    end

    always @(posedge MCLK) begin
        if (!RSTN) begin
            RDATA <= 32'h00000000;
        end else if (CE) begin
            RDATA <= RD ? rd_d : 32'h00000000;
        end
    end
endmodule // mfc_top

// >>> tb/mfc_host.sv
// Purpose: Host controller model driving the register port.
// Assumes: Tasks are entered right after a rising clock edge.
// Notes: Read data are taken in the cycle after the read strobe.
`timescale 1ns/1ps
module mfc_host (
    // Clock.
    input wire mclk,
    // Register port.
    output reg [7:0] addr,
    output reg [31:0] wdata,
    output reg wr,
    output reg rd,
    input wire [31:0] rdata
);
    initial begin
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
    end
    task wr_reg(input [7:0] a, input [31:0] d);
        begin
            addr <= a;
            wdata <= d;
            wr <= 1'b1;
            @(posedge mclk);
            wr <= 1'b0;
            @(posedge mclk);
        end
    endtask
    task rd_reg(input [7:0] a, output [31:0] d);
        begin
            addr <= a;
            rd <= 1'b1;
            @(posedge mclk);
            rd <= 1'b0;
            @(posedge mclk);
            d = rdata;
        end
    endtask
endmodule // mfc_host

// >>> tb/mfc_top_sva.sv
// Purpose: Checker on the register port and interrupt outputs.
// Assumes: Sees only the top ports; CE low pauses the checks.
// Notes: Bound to mfc_top below.
`timescale 1ns/1ps
module mfc_top_sva #(
    parameter NCH = 5
) (
    // Clock and control.
    input wire MCLK,
    input wire RSTN,
    input wire CE,
    // Register port.
    input wire [7:0] ADDR,
    input wire [31:0] WDATA,
    input wire WR,
    input wire RD,
    input wire [31:0] RDATA,
    // Strap and interrupts.
    input wire FREQ_MODE,
    input wire [NCH-1:0] IRQ_REQ
);
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RSTN || !CE);
    a_reset_quiet: assert property (@(posedge MCLK) disable iff (!CE)
        !RSTN |=> IRQ_REQ == {NCH{1'b0}} && RDATA == 32'h0) else $error("reset out");
    a_sample_init: assert property ($rose(RSTN) ##1 (RD && ADDR == 8'h00)
        |=> RDATA == 32'h0) else $error("sample init");
    a_sample_back: assert property ((WR && ADDR == 8'h00 && WDATA[6:4] < 3'h5)
        ##2 (RD && ADDR == 8'h00) |=> RDATA == ($past(WDATA, 3) & 32'h7f))
        else $error("sample back");
    a_mod_back: assert property ((WR && ADDR == 8'h44) ##2 (RD && ADDR == 8'h44)
        |=> RDATA == ($past(WDATA, 3) & 32'hffff)) else $error("modulus back");
    a_mod_width: assert property ((RD && ADDR > 8'h40 && ADDR < 8'h90
        && ADDR[3:0] == 4'h4) |=> RDATA[31:16] == 16'h0) else $error("modulus width");
    a_arm_back: assert property ((WR && ADDR == 8'h08) ##2 (RD && ADDR == 8'h08)
        |=> ($past(WDATA, 3) & ~RDATA & 32'h1f) == 32'h0) else $error("arm back");
    a_svc_disarm: assert property ((WR && ADDR == 8'h10 && WDATA[0] && IRQ_REQ[0])
        ##2 (RD && ADDR == 8'h08) |=> !RDATA[0]) else $error("service disarm");
    a_function_select_reject: assert property ((FREQ_MODE && WR && ADDR == 8'h40)
        ##2 (RD && ADDR == 8'h14) |=> RDATA[0]) else $error("function_select reject");
    a_card_strap: assert property ((RD && ADDR == 8'h18)
        |=> RDATA == {31'h0, $past(FREQ_MODE)}) else $error("strap read");
endmodule // mfc_top_sva
bind mfc_top mfc_top_sva #(.NCH(NCH)) u_sva (.MCLK(MCLK), .RSTN(RSTN), .CE(CE),
    .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .FREQ_MODE(FREQ_MODE), .IRQ_REQ(IRQ_REQ));

// >>> tb/mfc_top_tb.sv
// Purpose: Self-checking bench for the counter card timing block.
// Assumes: CE held high; inputs change right after a rising edge.
// Notes: Input pulses, except the short one in t_sample, outlast two sample ticks so the debounce takes them.
`timescale 1ns/1ps
module mfc_top_tb;
    reg mclk;
    reg rstn;
    reg freq_mode;
    reg [9:0] inp;
    wire [7:0] addr;
    wire [31:0] wdata;
    wire wr;
    wire rd;
    wire [31:0] rdata;
    wire [4:0] irq;
    reg [31:0] v;
    integer fail_count;
    integer comparisons;
    integer i;
    mfc_top u_dut (.MCLK(mclk), .RSTN(rstn), .CE(1'b1), .ADDR(addr), .WDATA(wdata),
        .WR(wr), .RD(rd), .RDATA(rdata), .FREQ_MODE(freq_mode), .IN_A(inp[4:0]),
        .IN_B(inp[9:5]), .IRQ_REQ(irq));
    mfc_host u_host (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            comparisons = comparisons + 1;
            if (seen !== exp) begin
                fail_count = fail_count + 1;
                $display("BAD %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask
    task tally_and_finish;
        begin
            if (fail_count == 0 && comparisons > 0)
                $display("[ PASS ]");
            else
                $display("[ FAIL ]");
            $finish;
        end
    endtask
    task rchk(input string nm, input [7:0] a, input [31:0] exp);
        begin
            u_host.rd_reg(a, v);
            check(nm, v, exp);
        end
    endtask
    task pulse(input integer k, input integer n);
        begin
            inp[k] <= 1'b1;
            repeat (n) @(posedge mclk);
            inp[k] <= 1'b0;
            repeat (n) @(posedge mclk);
        end
    endtask
    // Periods of 8 us then 16 us on channel 3, then waits for the result.
    task measure(input [31:0] fn);
        begin
            u_host.wr_reg(8'h74, 32'h2);
            u_host.wr_reg(8'h70, fn);
            u_host.wr_reg(8'h08, 32'h8);
            pulse(3, 100);
            pulse(3, 200);
            pulse(3, 100);
            v = 32'h0;
            for (i = 0; i < 20 && v[2] !== 1'b1; i = i + 1)
                u_host.rd_reg(8'h7c, v);
            if (v[2] !== 1'b1) begin
                fail_count = fail_count + 1;
                tally_and_finish;
            end
            check("rdy irq", {27'h0, irq}, 32'h8);
            u_host.rd_reg(8'h78, v);
        end
    endtask
    task t_reset;
        begin
            rchk("sample", 8'h00, 32'h0);
            rchk("gate", 8'h04, 32'h0);
            rchk("ctrl", 8'h40, 32'h0);
            rchk("modulus", 8'h44, 32'h2);
            rchk("arm", 8'h08, 32'h0);
            rchk("strap", 8'h18, 32'h0);
            rchk("unmapped", 8'h20, 32'h0);
        end
    endtask
    task t_wrap;
        begin
            u_host.wr_reg(8'h40, 32'h1);
            u_host.wr_reg(8'h44, 32'h3);
            rchk("mod back", 8'h44, 32'h3);
            u_host.wr_reg(8'h08, 32'h1);
            rchk("arm back", 8'h08, 32'h1);
            pulse(0, 80);
            pulse(0, 80);
            rchk("wrap two", 8'h48, 32'h2);
            check("no ovf", {27'h0, irq}, 32'h0);
            pulse(0, 80);
            rchk("wrap zero", 8'h48, 32'h0);
            check("ovf", {27'h0, irq}, 32'h1);
            u_host.wr_reg(8'h10, 32'h1);
            check("svc", {27'h0, irq}, 32'h0);
            rchk("svc arm", 8'h08, 32'h0);
        end
    endtask
    task t_updn;
        begin
            u_host.wr_reg(8'h50, 32'h3);
            u_host.wr_reg(8'h54, 32'h4);
            u_host.wr_reg(8'h08, 32'h2);
            pulse(6, 80);
            rchk("down wrap", 8'h58, 32'h3);
            pulse(1, 80);
            rchk("up wrap", 8'h58, 32'h0);
            check("updn quiet", {27'h0, irq}, 32'h0);
            u_host.wr_reg(8'h0c, 32'h2);
            rchk("disarm", 8'h08, 32'h0);
        end
    endtask
    task t_cdir;
        begin
            u_host.wr_reg(8'h60, 32'h5);
            u_host.wr_reg(8'h64, 32'h4);
            inp[7] <= 1'b0;
            repeat (80) @(posedge mclk);
            pulse(2, 80);
            rchk("dir down", 8'h68, 32'h3);
            inp[7] <= 1'b1;
            repeat (80) @(posedge mclk);
            pulse(2, 80);
            rchk("dir up", 8'h68, 32'h0);
            check("cdir quiet", {27'h0, irq}, 32'h0);
        end
    endtask
    task t_period;
        begin
            measure(32'h7);
            check("period sum", v > 32'd22 && v < 32'd26, 32'h1);
            check("read clears", {27'h0, irq}, 32'h0);
        end
    endtask
    task t_delayed;
        begin
            measure(32'h8);
            check("second period", v > 32'd14 && v < 32'd18, 32'h1);
        end
    endtask
    task t_freq;
        begin
            freq_mode <= 1'b1;
            repeat (2) @(posedge mclk);
            rchk("strap hi", 8'h18, 32'h1);
            u_host.wr_reg(8'h40, 32'h2);
            rchk("err", 8'h14, 32'h1);
            rchk("ctrl kept", 8'h40, 32'h1);
            u_host.wr_reg(8'h14, 32'h0);
            rchk("err clr", 8'h14, 32'h0);
            freq_mode <= 1'b0;
        end
    endtask
    task t_sample;
        begin
            u_host.wr_reg(8'h00, 32'h11);
            rchk("sample back", 8'h00, 32'h11);
            pulse(4, 40);
            rchk("short pulse", 8'h88, 32'h0);
            pulse(4, 1500);
            rchk("long pulse", 8'h88, 32'h1);
        end
    endtask
    initial begin
        rstn = 1'b0;
        freq_mode = 1'b0;
        inp = 10'h000;
        fail_count = 0;
        comparisons = 0;
        repeat (2) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        t_reset;
        t_wrap;
        t_updn;
        t_cdir;
        t_period;
        t_delayed;
        t_freq;
        t_sample;
        tally_and_finish;
    end
endmodule // mfc_top_tb
